// ### hdl/exc_pkg.sv
package exc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MSTP_A     = 8'h00;
  localparam logic [7:0] OFF_MSTP_B     = 8'h04;
  localparam logic [7:0] OFF_MSTP_C     = 8'h08;
  localparam logic [7:0] OFF_SYSCTRL    = 8'h0c;
  localparam logic [7:0] OFF_SENSE      = 8'h10;
  localparam logic [7:0] OFF_ENABLE     = 8'h14;
  localparam logic [7:0] OFF_PRIO       = 8'h18;
  localparam logic [7:0] OFF_PENDING    = 8'h1c;
  localparam logic [7:0] OFF_CPU_STATE  = 8'h20;
  // reset values
  localparam logic [7:0] MSTP_A_RESET   = 8'h3f;
  localparam logic [7:0] MSTP_BC_RESET  = 8'hff;
  localparam logic [1:0] MODE_0         = 2'h0;
  localparam logic [1:0] MODE_2         = 2'h2;
  // field positions
  localparam int SYS_MODE_LO = 4;
  localparam int SYS_NMI_EDGE = 3;
  localparam int EXR_TRACE = 7;
  localparam int CCR_MASK = 7;
  localparam int CCR_USER = 6;
  // vector numbers
  localparam logic [6:0] VEC_TRACE = 7'h05;
  localparam logic [6:0] VEC_NMI   = 7'h07;
  localparam logic [6:0] VEC_TRAP0 = 7'h08;
  localparam logic [6:0] VEC_EXT0  = 7'h10;
  localparam logic [3:0] NMI_LEVEL = 4'h8;
  localparam int N_EXT = 6;
  localparam int N_MOD = 24;
  // steps of entry
  localparam int STACK_WORDS = 4;
  typedef enum logic [2:0] {none_e, reset_e, trace_e, direct_e, irq_e, trap_e} exc_kind_t;
endpackage : exc_pkg

// ### hdl/exc_sense_if.sv
`timescale 1ns/1ns
`default_nettype none
// sensed external requests, shared between edge logic and sequencer
interface exc_sense_if;
  logic [5:0] pend;
  logic [5:0] clr;
  logic       nmi_pend;
  logic       nmi_clr;
  modport sense (output pend, output nmi_pend, input clr, input nmi_clr);
  modport core  (input pend, input nmi_pend, output clr, output nmi_clr);
endinterface : exc_sense_if
`default_nettype wire

// ### hdl/exc_req_sense.sv
`timescale 1ns/1ns
`default_nettype none
module exc_req_sense (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // pins
  input  wire logic        nmi_pin,
  input  wire logic [5:0]  ext_request,
  // configuration
  input  wire logic        nmi_rising,
  input  wire logic [11:0] sense_sel,
  // to sequencer
  exc_sense_if.sense       sn
);
  logic [5:0] s1, s2, s3;
  logic       n1, n2, n3;

  // two-flop synchronisers, third stage for edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 6'h3f; s2 <= 6'h3f; s3 <= 6'h3f;
      n1 <= 1'h0;  n2 <= 1'h0;  n3 <= 1'h0;
    end else begin
      s1 <= ext_request; s2 <= s1; s3 <= s2;
      n1 <= nmi_pin; n2 <= n1; n3 <= n2;
    end
  end

  // nmi edge latch; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) sn.nmi_pend <= 1'h0;
    else if (nmi_rising ? (n2 && !n3) : (!n2 && n3)) sn.nmi_pend <= 1'h1;
    else if (sn.nmi_clr) sn.nmi_pend <= 1'h0;
  end

  // per-input sense: 00 low, 01 fall, 10 rise, 11 both
  always_ff @(posedge aclk) begin
    if (!aresetn) sn.pend <= 6'h00;
    else begin
      for (int i = 0; i < 6; i++) begin
        case (sense_sel[2*i +: 2])
          2'h0: sn.pend[i] <= !s2[i];
          2'h1: sn.pend[i] <= (!s2[i] && s3[i]) || (sn.pend[i] && !sn.clr[i]);
          2'h2: sn.pend[i] <= (s2[i] && !s3[i]) || (sn.pend[i] && !sn.clr[i]);
          default: sn.pend[i] <= (s2[i] != s3[i]) || (sn.pend[i] && !sn.clr[i]);
        endcase
      end
    end
  end
endmodule : exc_req_sense
`default_nettype wire

// ### hdl/exception_entry_sequencer.sv
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - reset loads module stops 3f, ff, ff
// - stopped module register access is blocked
// - trace only in control mode 2
// - trace after each instruction, ignores masking
// - trace entry sets mask, clears trace bit
// - stacked trace stays 1; no trace after return
// - interrupts still accepted inside trace handler
// - stack, update mask and trace, fetch vector
// - software trap uses the same entry sequence
// - trap field picks one of four vectors
// - trap sets mask; clears trace in mode 2
// - word accesses force lowest address bit zero
// - two control modes from system control bits
// - eight levels per module; nmi level 8
// - each source has its own vector
// - nmi edge selectable rising or falling
// - external inputs: fall, rise, both, low level
// - control mode 0 after reset
// - priority: reset, trace, direct, interrupt, trap
// - priority field binary, 000 lowest
// - all interrupts off until first instruction
module exception_entry_sequencer (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt pins
  input  wire logic        nmi_pin,
  input  wire logic [5:0]  ext_request,
  // internal interrupt sources, one per module
  input  wire logic [23:0] int_request,
  input  wire logic        direct_transition,
  // cpu sequencer
  input  wire logic        instr_done,
  input  wire logic        instr_is_rte,
  input  wire logic        instr_no_detect,
  input  wire logic        trap_exec,
  input  wire logic [1:0]  trap_number,
  input  wire logic [23:0] cur_pc,
  input  wire logic [7:0]  condition_code_in,
  input  wire logic [7:0]  extended_control_in,
  input  wire logic [31:0] stack_pointer_reg,
  output logic             entry_busy,
  output logic             stack_we,
  output logic [31:0]      stack_addr,
  output logic [15:0]      stack_data,
  output logic             vector_fetch,
  output logic [6:0]       vector_number,
  output logic [7:0]       condition_code_reg,
  output logic [7:0]       extended_control_reg,
  output logic [31:0]      next_stack_pointer,
  // peripheral access gate
  input  wire logic [4:0]  periph_sel,
  input  wire logic        periph_req,
  output logic             periph_allow
);
  exc_sense_if sn ();

  logic [7:0]  module_stop_ctrl_a, module_stop_ctrl_b, module_stop_ctrl_c;
  logic [7:0]  system_control_reg;
  logic [11:0] sense_sel;
  logic [5:0]  ext_enable;
  logic [23:0] prio_flat;          // 3 bits per field, 8 fields; module m uses field m % 8
  logic        first_done;
  logic [1:0]  ctrl_mode;
  exc_pkg::exc_kind_t kind;
  logic [2:0]  step;
  logic [6:0]  pend_vec;
  logic [2:0]  pend_lvl;
  logic [31:0] sp;
  logic        wr_a, wr_d;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;

  exc_req_sense u_sense (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .nmi_pin    (nmi_pin),
    .ext_request(ext_request),
    .nmi_rising (system_control_reg[exc_pkg::SYS_NMI_EDGE]),
    .sense_sel  (sense_sel),
    .sn         (sn)
  );

  // mode field: two select bits, only 0 and 2 legal
  assign ctrl_mode = system_control_reg[exc_pkg::SYS_MODE_LO +: 2];

  // word-aligned stack address
  function automatic logic [31:0] even_addr(input logic [31:0] a);
    even_addr = {a[31:1], 1'b0};
  endfunction : even_addr

  // priority lookup for a module number, level 0..7
  function automatic logic [2:0] level_of(input logic [23:0] p, input int m);
    level_of = p[3*(m % 8) +: 3];
  endfunction : level_of

  // arbitration among interrupt sources
  logic       irq_any;
  logic [6:0] irq_vec;
  logic [2:0] irq_lvl;
  logic       irq_nmi;
  always_comb begin
    irq_any = 1'b0;
    irq_vec = exc_pkg::VEC_NMI;
    irq_lvl = 3'h0;
    irq_nmi = 1'b0;
    if (sn.nmi_pend) begin
      irq_any = 1'b1;
      irq_nmi = 1'b1;
      irq_lvl = 3'h7;
    end else begin
      for (int m = 0; m < exc_pkg::N_MOD; m++) begin
        if (int_request[m] && (!irq_any || level_of(prio_flat, m) > irq_lvl)) begin
          irq_any = 1'b1;
          irq_lvl = level_of(prio_flat, m);
          irq_vec = 7'(24 + m);
        end
      end
      for (int e = 0; e < exc_pkg::N_EXT; e++) begin
        if (sn.pend[e] && ext_enable[e] && (!irq_any || level_of(prio_flat, e) > irq_lvl)) begin
          irq_any = 1'b1;
          irq_lvl = level_of(prio_flat, e);
          irq_vec = exc_pkg::VEC_EXT0 + 7'(e);
        end
      end
      // masking: mode 0 by ccr mask bit, mode 2 by level field
      if (ctrl_mode == exc_pkg::MODE_2) begin
        if (irq_any && irq_lvl <= extended_control_in[2:0]) irq_any = 1'b0;
      end else if (condition_code_in[exc_pkg::CCR_MASK]) begin
        irq_any = 1'b0;
      end
    end
  end

  // boundary arbitration; interrupts off until first instruction
  logic      trace_on;
  exc_pkg::exc_kind_t pick;
  assign trace_on = ctrl_mode == exc_pkg::MODE_2 && extended_control_in[exc_pkg::EXR_TRACE]
                    && !instr_is_rte;
  always_comb begin
    if (!instr_done) pick = exc_pkg::none_e;
    else if (trace_on) pick = exc_pkg::trace_e;
    else if (direct_transition) pick = exc_pkg::direct_e;
    else if (irq_any && first_done && !instr_no_detect) pick = exc_pkg::irq_e;
    else if (trap_exec) pick = exc_pkg::trap_e;
    else pick = exc_pkg::none_e;
  end

  // first completed instruction after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) first_done <= 1'b0;
    else if (instr_done) first_done <= 1'b1;
  end

  // entry sequencer: latch at boundary, start next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind <= exc_pkg::none_e;
      step <= 3'h0;
      pend_vec <= 7'h00;
      pend_lvl <= 3'h0;
      sp <= 32'h0;
      condition_code_reg <= 8'h80;
      extended_control_reg <= 8'h07;
    end else if (kind == exc_pkg::none_e) begin
      step <= 3'h0;
      if (pick != exc_pkg::none_e && pick != exc_pkg::direct_e) begin
        kind <= pick;
        sp <= stack_pointer_reg;
        condition_code_reg <= condition_code_in;
        extended_control_reg <= extended_control_in;
        pend_lvl <= irq_lvl;
        case (pick)
          exc_pkg::trace_e: pend_vec <= exc_pkg::VEC_TRACE;
          exc_pkg::trap_e:  pend_vec <= exc_pkg::VEC_TRAP0 + {5'h00, trap_number};
          default:          pend_vec <= irq_vec;
        endcase
      end
    end else if (step < 3'(exc_pkg::STACK_WORDS)) begin
      step <= step + 3'h1;
    end else if (step == 3'(exc_pkg::STACK_WORDS)) begin
      step <= step + 3'h1;
      condition_code_reg[exc_pkg::CCR_MASK] <= 1'b1;
      // trace cleared on every entry but a mode 0 trap
      if (ctrl_mode == exc_pkg::MODE_2 || kind != exc_pkg::trap_e) begin
        extended_control_reg[exc_pkg::EXR_TRACE] <= 1'b0;
      end
      // latched level, so a fresh nmi during entry cannot leak in
      if (ctrl_mode == exc_pkg::MODE_2 && kind == exc_pkg::irq_e) begin
        extended_control_reg[2:0] <= pend_lvl;
      end
    end else begin
      kind <= exc_pkg::none_e;
    end
  end

  // nmi acknowledge when its entry is taken; edge inputs cleared likewise
  always_comb begin
    sn.nmi_clr = pick == exc_pkg::irq_e && kind == exc_pkg::none_e && irq_vec == exc_pkg::VEC_NMI && sn.nmi_pend;
    sn.clr = 6'h00;
    for (int e = 0; e < exc_pkg::N_EXT; e++)
      if (pick == exc_pkg::irq_e && kind == exc_pkg::none_e && irq_vec == exc_pkg::VEC_EXT0 + 7'(e))
        sn.clr[e] = 1'b1;
  end

  // stack pushes: pc low, pc high with ccr, exr, a zero word, then vector
  assign entry_busy = kind != exc_pkg::none_e;
  assign stack_we = entry_busy && step < 3'(exc_pkg::STACK_WORDS);
  assign stack_addr = even_addr(sp - {28'h0, step + 3'h1, 1'b0});
  always_comb begin
    case (step)
      3'h0: stack_data = cur_pc[15:0];
      3'h1: stack_data = {condition_code_reg, cur_pc[23:16]};
      3'h2: stack_data = {extended_control_reg, 8'h00};  // stacked trace bit unchanged
      default: stack_data = 16'h0000;
    endcase
  end
  assign vector_fetch = entry_busy && step == 3'(exc_pkg::STACK_WORDS) + 3'h1;
  assign vector_number = pend_vec;
  assign next_stack_pointer = even_addr(sp - 32'(2 * exc_pkg::STACK_WORDS));

  // module stop gating of peripheral access
  assign periph_allow = periph_req && !(periph_sel < 5'h8 ? module_stop_ctrl_a[periph_sel[2:0]] :
                        periph_sel < 5'h10 ? module_stop_ctrl_b[periph_sel[2:0]] :
                        module_stop_ctrl_c[periph_sel[2:0]]);

  // axi write: take address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_a <= 1'b0; wr_d <= 1'b0; wr_addr <= 8'h00; wr_data <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin wr_a <= 1'b1; wr_addr <= s_axi_awaddr; end
      if (s_axi_wvalid && s_axi_wready) begin wr_d <= 1'b1; wr_data <= s_axi_wdata; end
      if (wr_a && wr_d) begin wr_a <= 1'b0; wr_d <= 1'b0; s_axi_bvalid <= 1'b1; end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !wr_a && !s_axi_bvalid;
  assign s_axi_wready = !wr_d && !s_axi_bvalid;
  assign s_axi_bresp = 2'h0;

  // register writes; low byte except sense and priority, mode bits of 1 forced legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_stop_ctrl_a <= exc_pkg::MSTP_A_RESET;
      module_stop_ctrl_b <= exc_pkg::MSTP_BC_RESET;
      module_stop_ctrl_c <= exc_pkg::MSTP_BC_RESET;
      system_control_reg <= 8'h00;
      sense_sel <= 12'h000;
      ext_enable <= 6'h00;
      prio_flat <= 24'hffffff;
    end else if (wr_a && wr_d) begin
      case (wr_addr)
        exc_pkg::OFF_MSTP_A:  module_stop_ctrl_a <= wr_data[7:0];
        exc_pkg::OFF_MSTP_B:  module_stop_ctrl_b <= wr_data[7:0];
        exc_pkg::OFF_MSTP_C:  module_stop_ctrl_c <= wr_data[7:0];
        exc_pkg::OFF_SYSCTRL: system_control_reg <= {2'h0, wr_data[5], 1'b0, wr_data[3:0]};
        exc_pkg::OFF_SENSE:   sense_sel <= wr_data[11:0];
        exc_pkg::OFF_ENABLE:  ext_enable <= wr_data[5:0];
        exc_pkg::OFF_PRIO:    prio_flat <= wr_data[23:0];
        default: ;
      endcase
    end
  end

  // axi read, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        exc_pkg::OFF_MSTP_A:    s_axi_rdata <= {24'h0, module_stop_ctrl_a};
        exc_pkg::OFF_MSTP_B:    s_axi_rdata <= {24'h0, module_stop_ctrl_b};
        exc_pkg::OFF_MSTP_C:    s_axi_rdata <= {24'h0, module_stop_ctrl_c};
        exc_pkg::OFF_SYSCTRL:   s_axi_rdata <= {24'h0, system_control_reg};
        exc_pkg::OFF_SENSE:     s_axi_rdata <= {20'h0, sense_sel};
        exc_pkg::OFF_ENABLE:    s_axi_rdata <= {26'h0, ext_enable};
        exc_pkg::OFF_PRIO:      s_axi_rdata <= {8'h0, prio_flat};
        exc_pkg::OFF_PENDING:   s_axi_rdata <= {25'h0, sn.nmi_pend, sn.pend};
        exc_pkg::OFF_CPU_STATE: s_axi_rdata <= {13'h0, kind, extended_control_reg, condition_code_reg};
        default: begin s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h2; end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule : exception_entry_sequencer
`default_nettype wire

// ### dv/exc_entry_properties.sv
`timescale 1ns/1ns
`default_nettype none
module exc_entry_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // cpu side
  input wire logic        instr_done,
  input wire logic        trap_exec,
  input wire logic        direct_transition,
  input wire logic        entry_busy,
  input wire logic        stack_we,
  input wire logic [31:0] stack_addr,
  input wire logic        vector_fetch,
  input wire logic [6:0]  vector_number,
  input wire logic [7:0]  condition_code_reg,
  input wire logic [7:0]  extended_control_reg,
  input wire logic [31:0] next_stack_pointer
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // four pushes, one quiet mask step, then the vector read
  sequence push_s; stack_we [*4]; endsequence
  sequence fetch_s; !stack_we && !vector_fetch ##1 vector_fetch; endsequence
  chk_entry_order: assert property ($rose(entry_busy) |-> push_s ##1 fetch_s)
    else $error("entry steps out of order");
  chk_fetch_closes: assert property (vector_fetch |-> entry_busy ##1 !entry_busy)
    else $error("busy not ended after vector read");
  chk_trap_enters: assert property (instr_done && trap_exec && !direct_transition && !entry_busy
    |=> entry_busy)
    else $error("trap did not start entry next cycle");
  chk_mask_on_fetch: assert property (vector_fetch |-> condition_code_reg[7])
    else $error("mask bit clear at vector read");
  chk_trace_clears: assert property (vector_fetch && vector_number == 7'h05 |-> !extended_control_reg[7])
    else $error("trace bit kept after trace entry");
  chk_stack_even: assert property (stack_we |-> !stack_addr[0] && !next_stack_pointer[0])
    else $error("odd stack address");
  chk_vector_known: assert property (vector_fetch |-> vector_number inside {5, 7, [8:11], [16:21], [24:47]})
    else $error("vector outside the table");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule : exc_entry_properties
bind exception_entry_sequencer exc_entry_properties u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .instr_done, .trap_exec, .entry_busy,
  .direct_transition,
  .stack_we, .stack_addr, .vector_fetch, .vector_number, .condition_code_reg, .extended_control_reg,
  .next_stack_pointer);
`default_nettype wire

// ### dv/cpu_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_seq_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // requests from the bench
  input  wire logic        step,
  input  wire logic        trap_req,
  input  wire logic [1:0]  trap_sel,
  input  wire logic        rte_req,
  input  wire logic        trace_on,
  // sequencer handshake
  input  wire logic        entry_busy,
  output logic             instr_done,
  output logic             instr_is_rte,
  output logic             trap_exec,
  output logic [1:0]       trap_number,
  // cpu state
  output logic [23:0]      cur_pc,
  output logic [7:0]       condition_code_in,
  output logic [7:0]       extended_control_in,
  output logic [31:0]      stack_pointer_reg
);
  // one boundary per request; none offered while entry runs
  always_ff @(posedge aclk) begin
    instr_done   <= aresetn && step && !entry_busy;
    instr_is_rte <= step && rte_req;
    trap_exec    <= step && trap_req;
    trap_number  <= trap_sel;
  end
  // pc moves one word per instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) cur_pc <= 24'h000100;
    else if (instr_done) cur_pc <= cur_pc + 24'h000002;
  end
  // software keeps the stack even; mask open so requests can win
  assign stack_pointer_reg   = 32'h0000fff0;
  assign condition_code_in   = 8'h00;
  assign extended_control_in = {trace_on, 7'h00};
endmodule : cpu_seq_model
`default_nettype wire

// ### dv/exception_entry_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h want %h", $time, (a), (b)); end end
module exception_entry_sequencer_tb;
  logic        aclk, aresetn, got, step, trap_req, rte_req, trace_on, nmi_pin, periph_req, periph_allow;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        instr_done, instr_is_rte, trap_exec, entry_busy, stack_we, vector_fetch;
  logic [1:0]  s_axi_bresp, s_axi_rresp, trap_number, trap_sel, rr;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  periph_sel;
  logic [5:0]  ext_request;
  logic [6:0]  vector_number, vec;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, condition_code_in, extended_control_in, condition_code_reg;
  logic [7:0]  extended_control_reg, cc, ex;
  logic [15:0] stack_data, sd;
  logic [23:0] cur_pc, int_request;
  logic [31:0] s_axi_wdata, s_axi_rdata, stack_pointer_reg, stack_addr, next_stack_pointer, rd;
  int          errors, n_tests;
  exception_entry_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin, .ext_request,
    .int_request, .direct_transition(1'b0), .instr_done, .instr_is_rte, .instr_no_detect(1'b0), .trap_exec,
    .trap_number, .cur_pc, .condition_code_in, .extended_control_in, .stack_pointer_reg, .entry_busy, .stack_we,
    .stack_addr, .stack_data, .vector_fetch, .vector_number, .condition_code_reg, .extended_control_reg,
    .next_stack_pointer, .periph_sel, .periph_req, .periph_allow);
  cpu_seq_model cpu (.aclk, .aresetn, .step, .trap_req, .trap_sel, .rte_req, .trace_on, .entry_busy, .instr_done,
    .instr_is_rte, .trap_exec, .trap_number, .cur_pc, .condition_code_in, .extended_control_in, .stack_pointer_reg);
  // single place where the run ends
  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // a wait that ran dry counts as a mismatch
  task automatic hang;
    errors++;
    $display("[FAIL] %0t no answer", $time);
    give_verdict();
  endtask : hang
  // ready sampled at the falling edge so the rising edge sees no race
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (40) begin
      ah = s_axi_awvalid && s_axi_awready;
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      if (bh) `CHK(s_axi_bresp, 2'h0)
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (40) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : rdr
  // offer one boundary, then catch the vector read and updated state
  task automatic ent(input logic t, input logic [1:0] n, input logic r);
    @(posedge aclk);
    step     <= 1'b1;
    trap_req <= t;
    trap_sel <= n;
    rte_req  <= r;
    @(posedge aclk);
    step <= 1'b0;
    got = 1'b0;
    {vec, cc, ex, sd} = '0;
    repeat (12) begin
      @(negedge aclk);
      if (stack_we === 1'b1 && stack_addr === 32'h0000ffee) sd = stack_data;
      if (vector_fetch === 1'b1 && !got) begin
        got = 1'b1;
        vec = vector_number;
        cc  = condition_code_reg;
        ex  = extended_control_reg;
      end
    end
    @(posedge aclk);
  endtask : ent
  // external pin 0: drop, optionally raise, then one boundary
  task automatic pin_event(input logic rise);
    ext_request[0] <= 1'b0;
    repeat (4) @(posedge aclk);
    if (rise) ext_request[0] <= 1'b1;
    repeat (4) @(posedge aclk);
    ent(1'b0, 2'h0, 1'b0);
    ext_request[0] <= 1'b1;
  endtask : pin_event
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {aresetn, step, trap_req, trap_sel, rte_req, trace_on, nmi_pin, periph_req, periph_sel} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    ext_request = 6'h3f;
    int_request = 24'h000000;
    errors = 0;
    n_tests = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(condition_code_reg, 8'h80)
    rdr(exc_pkg::OFF_MSTP_A); `CHK(rd, 32'h0000003f)
    rdr(exc_pkg::OFF_MSTP_B); `CHK(rd, 32'h000000ff)
    rdr(exc_pkg::OFF_MSTP_C); `CHK(rd, 32'h000000ff)
    rdr(exc_pkg::OFF_SYSCTRL); `CHK(rd[5:4], exc_pkg::MODE_0)
    rdr(8'h40); `CHK({rr, rd}, {2'h2, 32'h00000000})
    periph_req <= 1'b1;
    @(negedge aclk); `CHK(periph_allow, 1'b0)
    wr(exc_pkg::OFF_MSTP_A, 32'h0000003e);
    @(negedge aclk); `CHK(periph_allow, 1'b1)
    @(posedge aclk);
    periph_sel <= 5'd8;
    @(negedge aclk); `CHK(periph_allow, 1'b0)
    // mode 0: trace bit set but no trace; traps keep it
    trace_on <= 1'b1;
    ent(1'b0, 2'h0, 1'b0); `CHK(got, 1'b0)
    for (int n = 0; n < 4; n++) begin
      ent(1'b1, n[1:0], 1'b0);
      `CHK(vec, exc_pkg::VEC_TRAP0 + 7'(n))
      `CHK({cc, ex}, {8'h80, 8'h80})
      `CHK(sd, cur_pc[15:0])
      `CHK(next_stack_pointer, 32'h0000ffe8)
    end
    wr(exc_pkg::OFF_ENABLE, 32'h00000001);
    // every sense code of external pin 0
    for (int c = 0; c < 4; c++) begin
      wr(exc_pkg::OFF_SENSE, 32'(c));
      pin_event(c != 0);
      `CHK(vec, exc_pkg::VEC_EXT0)
      `CHK({cc[7], ex[7]}, 2'b10)
    end
    wr(exc_pkg::OFF_ENABLE, 32'h00000000);
    wr(exc_pkg::OFF_SYSCTRL, 32'h00000008);
    nmi_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    ent(1'b0, 2'h0, 1'b0); `CHK(vec, exc_pkg::VEC_NMI)
    wr(exc_pkg::OFF_SYSCTRL, 32'h00000000);
    nmi_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    ent(1'b0, 2'h0, 1'b0); `CHK(vec, exc_pkg::VEC_NMI)
    // mode 2: trace wins, clears its bit, skips the return
    wr(exc_pkg::OFF_SYSCTRL, 32'h00000020);
    rdr(exc_pkg::OFF_SYSCTRL); `CHK(rd[5:4], exc_pkg::MODE_2)
    trace_on <= 1'b1;
    ent(1'b0, 2'h0, 1'b0); `CHK(vec, exc_pkg::VEC_TRACE)
    `CHK({cc, ex}, {8'h80, 8'h00})
    ent(1'b1, 2'h2, 1'b0); `CHK(vec, exc_pkg::VEC_TRACE)
    ent(1'b0, 2'h0, 1'b1); `CHK(got, 1'b0)
    trace_on <= 1'b0;
    wr(exc_pkg::OFF_PRIO, 32'h00fffffd);
    wr(exc_pkg::OFF_SENSE, 32'h00000001);
    wr(exc_pkg::OFF_ENABLE, 32'h00000001);
    pin_event(1'b1);
    `CHK({vec, ex[2:0]}, {exc_pkg::VEC_EXT0, 3'h5})
    int_request <= 24'h000200;
    ent(1'b0, 2'h0, 1'b0); `CHK({vec, ex[2:0]}, {7'h21, 3'h7})
    give_verdict();
  end
endmodule : exception_entry_sequencer_tb
`default_nettype wire
